// ==== mcuor_core_model.sv ====
// Purpose: Core-side model issuing program counter requests.
// Assumes: A change is followed by its flush cycle.
// Notes: op 0 jump, 1 call, 2 return, 3 step.
module mcuor_core_model
  import mcuor_pkg::*;
(
  input wire logic clk,
  output logic pc_advance,
  output logic pc_jump,
  output logic pc_call,
  output logic pc_ret,
  output logic [PC_W-1:0] pc_target
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels
  initial begin
    {pc_advance, pc_jump, pc_call, pc_ret} = 4'h0;
    pc_target = '0;
  end
  // One request, then one idle edge for the flush
  task automatic issue(input int op, input logic [PC_W-1:0] t);
    pc_target <= t;
    pc_jump <= (op == 0);
    pc_call <= (op == 1);
    pc_ret <= (op == 2);
    pc_advance <= (op == 3);
    @(posedge clk);
    {pc_advance, pc_jump, pc_call, pc_ret} <= 4'h0;
    pc_target <= ~t;
    @(posedge clk);
  endtask
endmodule

// ==== mcuor_pcstack.sv ====
// Purpose: Program counter and hardware return stack.
// Assumes: Core raises at most the requests it means each cycle.
// Notes: Stack wraps on overflow and underflow.
module mcuor_pcstack
  import mcuor_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic advance,
  input wire logic jump,
  input wire logic call,
  input wire logic ret,
  input wire logic [PC_W-1:0] target,
  input wire logic low_wr,
  input wire logic [7:0] low_val,
  output logic [PC_W-1:0] pc,
  output logic flush
);
  localparam int unsigned SP_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [SP_W-1:0] SP_LAST = SP_W'(DEPTH - 1);

  if (DEPTH < 2 || PROG_WORDS != (1 << PC_W)) begin : g_check
    $error("mcuor_pcstack: unsupported stack depth or page size");
  end

  typedef struct packed {
    mcuor_pcst_e st;
    logic [PC_W-1:0] pc;
    logic [SP_W-1:0] sp;
    logic [DEPTH-1:0][PC_W-1:0] stk;
  } mcuor_pc_s;

  mcuor_pc_s s_q, s_d;
  logic [SP_W-1:0] sp_dn;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    sp_dn = (s_q.sp == '0) ? SP_LAST : s_q.sp - SP_W'(1);
    case (s_q.st)
      PCS_RUN: begin
        if (jump) begin
          s_d.pc = target;
          s_d.st = PCS_FLUSH;
        end else if (call) begin
          s_d.stk[s_q.sp] = s_q.pc + PC_W'(1);
          s_d.sp = (s_q.sp == SP_LAST) ? '0 : s_q.sp + SP_W'(1);
          s_d.pc = target;
          s_d.st = PCS_FLUSH;
        end else if (ret) begin
          s_d.pc = s_q.stk[sp_dn];
          s_d.sp = sp_dn;
          s_d.st = PCS_FLUSH;
        end else if (low_wr) begin
          s_d.pc = {2'b00, low_val};
          s_d.st = PCS_FLUSH;
        end else if (advance) begin
          s_d.pc = s_q.pc + PC_W'(1);
        end
      end
      PCS_FLUSH: begin
        s_d.st = PCS_RUN;
      end
      default: begin
        s_d.st = PCS_RUN;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.st <= PCS_RUN;
      s_q.pc <= PC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign pc = s_q.pc;
  assign flush = (s_q.st == PCS_FLUSH);
endmodule

// ==== mcuor_pkg.sv ====
// Purpose: Shared constants and types of the operational register bank.
// Assumes: One clk edge is one instruction cycle of the core.
// Notes: Register offsets are the 6-bit data-space addresses of each page.
package mcuor_pkg;
  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 6;
  localparam int unsigned PC_W = 10;
  localparam int unsigned PROG_WORDS = 1024;
  localparam int unsigned STACK_DEPTH = 5;
  localparam int unsigned GP_WORDS = 32;

  // ****************************************
  // Main page offsets
  // ****************************************
  localparam logic [5:0] A_INDIRECT = 6'h00;
  localparam logic [5:0] A_TIMER = 6'h01;
  localparam logic [5:0] A_PC = 6'h02;
  localparam logic [5:0] A_STATUS = 6'h03;
  localparam logic [5:0] A_RAMPTR = 6'h04;
  localparam logic [5:0] A_PORT1 = 6'h05;
  localparam logic [5:0] A_PORT2 = 6'h06;
  localparam logic [5:0] A_IFLAGS = 6'h0f;
  localparam logic [5:0] A_GP_FIRST = 6'h10;
  localparam logic [5:0] A_GP_LAST = 6'h2f;

  // ****************************************
  // Control page offsets
  // ****************************************
  localparam logic [5:0] A_TCTRL = 6'h01;
  localparam logic [5:0] A_DIR1 = 6'h05;
  localparam logic [5:0] A_DIR2 = 6'h06;
  localparam logic [5:0] A_PULLDN = 6'h0b;
  localparam logic [5:0] A_OPENDR = 6'h0c;
  localparam logic [5:0] A_PULLUP = 6'h0d;
  localparam logic [5:0] A_WDCTRL = 6'h0e;
  localparam logic [5:0] A_IMASK = 6'h0f;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int unsigned ST_RST = 7;
  localparam int unsigned ST_GP1 = 6;
  localparam int unsigned ST_GP0 = 5;
  localparam int unsigned ST_TO = 4;
  localparam int unsigned ST_PD = 3;
  localparam int unsigned ST_Z = 2;
  localparam int unsigned ST_DC = 1;
  localparam int unsigned ST_C = 0;
  localparam int unsigned CT_IEN = 6;
  localparam int unsigned CT_SRC = 5;
  localparam int unsigned CT_EDGE = 4;
  localparam int unsigned CT_PAB = 3;
  localparam int unsigned CT_RATE_LSB = 0;
  localparam int unsigned WD_EN = 7;
  localparam int unsigned WD_EIS = 6;
  localparam int unsigned IF_EXT = 2;
  localparam int unsigned IF_CHG = 1;
  localparam int unsigned IF_TMR = 0;
  localparam int unsigned INPUT_ONLY_BIT = 3;
  localparam int unsigned EXT_IRQ_BIT = 0;

  // ****************************************
  // Implemented-bit masks and reset values
  // ****************************************
  localparam logic [7:0] PORT1_MASK = 8'h0f;
  localparam logic [7:0] IF_MASK = 8'h07;
  localparam logic [7:0] CT_MASK = 8'h7f;
  localparam logic [7:0] PULLDN_MASK = 8'h77;
  localparam logic [7:0] OPENDR_MASK = 8'hf7;
  localparam logic [7:0] PULLUP_MASK = 8'hf7;
  localparam logic [7:0] WD_MASK = 8'hc0;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'hff;
  localparam logic [7:0] PULL_RST = 8'hff;
  localparam logic [7:0] OPENDR_RST = 8'h00;
  localparam logic [7:0] WD_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [9:0] PC_RST = 10'h000;

  // ****************************************
  // Program counter sequencing states
  // ****************************************
  typedef enum logic [1:0] {
    PCS_RUN = 2'b01,
    PCS_FLUSH = 2'b10
  } mcuor_pcst_e;
endpackage

// ==== mcuor_regs.sv ====
// Purpose: Operational register bank of the core: data space, status, ports, flags.
// Assumes: One clk edge per instruction cycle; all pins synchronous to clk.
module mcuor_regs
  import mcuor_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_ioc_page,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic pc_advance,
  input wire logic pc_jump,
  input wire logic pc_call,
  input wire logic pc_ret,
  input wire logic [PC_W-1:0] pc_target,
  output logic [PC_W-1:0] prog_addr,
  output logic pc_flush,
  input wire logic alu_flag_we,
  input wire logic alu_zero,
  input wire logic alu_dc,
  input wire logic alu_carry,
  input wire logic sleep_exec,
  input wire logic wdt_clear_exec,
  input wire logic wdt_timeout,
  input wire logic cause_pin_wake,
  input wire logic cause_wdt,
  input wire logic wdt_osc_tick,
  input wire logic tcc_pin,
  input wire logic [3:0] port1_in,
  output logic [3:0] port1_out,
  output logic [3:0] port1_oe,
  input wire logic [7:0] port2_in,
  output logic [7:0] port2_out,
  output logic [7:0] port2_oe,
  output logic [7:0] pull_down_ctl,
  output logic [7:0] pull_up_ctl,
  output logic wdt_enable,
  output logic global_int_enable,
  output logic wdt_prescale_tick
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic init;
    logic [7:0] rdata;
    logic rvalid;
    logic [7:0] status;
    logic [7:0] ramptr;
    logic [7:0] lat1;
    logic [7:0] lat2;
    logic [7:0] ctrl;
    logic [7:0] dir1;
    logic [7:0] dir2;
    logic [7:0] pdn;
    logic [7:0] od;
    logic [7:0] pup;
    logic [7:0] wdc;
    logic [7:0] mask;
    logic [7:0] flags;
    logic [7:0] p2_prev;
    logic [3:0] p1_out;
    logic [3:0] p1_oe;
    logic [7:0] p2_out;
    logic [7:0] p2_oe;
    logic [GP_WORDS-1:0][7:0] gp;
  } mcuor_regs_s;

  mcuor_regs_s s_q, s_d;

  logic [ADDR_W-1:0] eff_addr;
  logic in_gp;
  logic [4:0] gp_idx;
  logic wr_main, wr_ioc;
  logic tmr_wr, pc_wr;
  logic [7:0] tmr_count;
  logic tmr_ovf;
  logic [PC_W-1:0] pc_val;
  logic [7:0] p1_view, p2_view;
  logic [7:0] if_set, if_keep;
  logic [7:0] rd_val;
  logic ext_fall, in_change;

  // ****************************************
  // Address decode
  // ****************************************
  // Indirect location redirects through the pointer
  assign eff_addr = (!reg_ioc_page && reg_addr == A_INDIRECT) ? s_q.ramptr[ADDR_W-1:0] : reg_addr;
  assign in_gp = (eff_addr >= A_GP_FIRST) && (eff_addr <= A_GP_LAST);
  assign gp_idx = 5'(eff_addr - A_GP_FIRST);
  assign wr_main = reg_wr & ~reg_ioc_page;
  assign wr_ioc = reg_wr & reg_ioc_page;
  assign tmr_wr = wr_main & (eff_addr == A_TIMER);
  assign pc_wr = wr_main & (eff_addr == A_PC);

  // ****************************************
  // Timer/counter and prescaler
  // ****************************************
  mcuor_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .ext_pin(tcc_pin),
    .src_ext(s_q.ctrl[CT_SRC]),
    .edge_fall(s_q.ctrl[CT_EDGE]),
    .pre_to_wdt(s_q.ctrl[CT_PAB]),
    .rate(s_q.ctrl[CT_RATE_LSB +: 3]),
    .wr(tmr_wr),
    .wdata(reg_wdata),
    .wdt_osc_tick(wdt_osc_tick),
    .wdt_clear(wdt_clear_exec | sleep_exec),
    .count(tmr_count),
    .ovf(tmr_ovf),
    .wdt_tick(wdt_prescale_tick)
  );

  // ****************************************
  // Program counter and return stack
  // ****************************************
  mcuor_pcstack #(
    .DEPTH(STACK_DEPTH)
  ) u_pc (
    .clk(clk),
    .nrst(nrst),
    .advance(pc_advance),
    .jump(pc_jump),
    .call(pc_call),
    .ret(pc_ret),
    .target(pc_target),
    .low_wr(pc_wr),
    .low_val(reg_wdata),
    .pc(pc_val),
    .flush(pc_flush)
  );

  // ****************************************
  // Port read views and pin events
  // ****************************************
  // Input bits read the pin, output bits read the latch
  always_comb begin
    p1_view = 8'h00;
    p2_view = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (PORT1_MASK[i]) begin
        p1_view[i] = s_q.dir1[i] ? port1_in[i[1:0]] : s_q.lat1[i];
      end
      p2_view[i] = (s_q.dir2[i] || i == INPUT_ONLY_BIT) ? port2_in[i] : s_q.lat2[i];
    end
  end

  // Falling edge of interrupt pin, change on any port 2 input bit
  assign ext_fall = s_q.wdc[WD_EIS] & s_q.p2_prev[EXT_IRQ_BIT] & ~port2_in[EXT_IRQ_BIT];
  assign in_change = ~s_q.init & (|((s_q.p2_prev ^ port2_in) & (s_q.dir2 | (8'h01 << INPUT_ONLY_BIT))));

  // Set terms for the sticky flags
  always_comb begin
    if_set = 8'h00;
    if_set[IF_EXT] = ext_fall;
    if_set[IF_CHG] = in_change;
    if_set[IF_TMR] = tmr_ovf;
    if_keep = (wr_main && eff_addr == A_IFLAGS) ? reg_wdata : 8'hff;
  end

  // ****************************************
  // Read multiplexer
  // ****************************************
  always_comb begin
    rd_val = 8'h00;
    if (!reg_ioc_page) begin
      if (in_gp) begin
        rd_val = s_q.gp[gp_idx];
      end else begin
        case (eff_addr)
          A_TIMER: rd_val = tmr_count;
          A_PC: rd_val = pc_val[7:0];
          A_STATUS: rd_val = s_q.status;
          A_RAMPTR: rd_val = s_q.ramptr;
          A_PORT1: rd_val = p1_view & PORT1_MASK;
          A_PORT2: rd_val = p2_view;
          A_IFLAGS: rd_val = s_q.flags & s_q.mask & IF_MASK;
          default: rd_val = 8'h00;
        endcase
      end
    end else begin
      case (reg_addr)
        A_TCTRL: rd_val = s_q.ctrl;
        A_DIR1: rd_val = s_q.dir1 & PORT1_MASK;
        A_DIR2: rd_val = s_q.dir2;
        A_PULLDN: rd_val = s_q.pdn;
        A_OPENDR: rd_val = s_q.od;
        A_PULLUP: rd_val = s_q.pup;
        A_WDCTRL: rd_val = s_q.wdc;
        A_IMASK: rd_val = s_q.mask;
        default: rd_val = 8'h00;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.init = 1'b0;
    s_d.rvalid = reg_rd;
    s_d.rdata = reg_rd ? rd_val : 8'h00;
    s_d.p2_prev = port2_in;

    // Main page writes; timer, PC and flag writes act elsewhere, other unlisted addresses ignore writes
    if (wr_main) begin
      if (in_gp) begin
        s_d.gp[gp_idx] = reg_wdata;
      end
      case (eff_addr)
        A_STATUS: begin
          s_d.status[ST_GP1] = reg_wdata[ST_GP1];
          s_d.status[ST_GP0] = reg_wdata[ST_GP0];
          s_d.status[ST_Z] = reg_wdata[ST_Z];
          s_d.status[ST_DC] = reg_wdata[ST_DC];
          s_d.status[ST_C] = reg_wdata[ST_C];
        end
        A_RAMPTR: s_d.ramptr = reg_wdata;
        A_PORT1: s_d.lat1 = reg_wdata & PORT1_MASK;
        A_PORT2: s_d.lat2 = reg_wdata;
        default: ;
      endcase
    end

    // Control page writes, reserved bits dropped
    if (wr_ioc) begin
      case (reg_addr)
        A_TCTRL: s_d.ctrl = reg_wdata & CT_MASK;
        A_DIR1: s_d.dir1 = (reg_wdata & PORT1_MASK) | ~PORT1_MASK;
        A_DIR2: s_d.dir2 = reg_wdata;
        A_PULLDN: s_d.pdn = (reg_wdata & PULLDN_MASK) | ~PULLDN_MASK;
        A_OPENDR: s_d.od = reg_wdata & OPENDR_MASK;
        A_PULLUP: s_d.pup = (reg_wdata & PULLUP_MASK) | ~PULLUP_MASK;
        A_WDCTRL: s_d.wdc = reg_wdata & WD_MASK;
        A_IMASK: s_d.mask = reg_wdata & IF_MASK;
        default: ;
      endcase
    end

    // Result flags from the ALU win over a software write
    if (alu_flag_we) begin
      s_d.status[ST_Z] = alu_zero;
      s_d.status[ST_DC] = alu_dc;
      s_d.status[ST_C] = alu_carry;
    end

    // Time-out and power-down events
    if (sleep_exec) begin
      s_d.status[ST_TO] = 1'b1;
      s_d.status[ST_PD] = 1'b0;
    end
    if (wdt_clear_exec) begin
      s_d.status[ST_TO] = 1'b1;
      s_d.status[ST_PD] = 1'b1;
    end
    if (wdt_timeout) begin
      s_d.status[ST_TO] = 1'b0;
    end

    // Reset cause caught in the first cycle after release
    if (s_q.init) begin
      s_d.status[ST_RST] = cause_pin_wake;
      s_d.status[ST_TO] = ~cause_wdt;
      s_d.status[ST_PD] = ~cause_pin_wake;
    end

    // Sticky flags: set wins over clear
    s_d.flags = ((s_q.flags & if_keep) | if_set) & IF_MASK;

    // Pin drivers from next latch, direction and open-drain
    for (int i = 0; i < 8; i++) begin
      if (i < 4) begin
        s_d.p1_out[i[1:0]] = s_d.lat1[i];
        s_d.p1_oe[i[1:0]] = ~s_d.dir1[i];
      end
      s_d.p2_out[i] = (i == INPUT_ONLY_BIT) ? 1'b0 : s_d.lat2[i];
      s_d.p2_oe[i] = (i == INPUT_ONLY_BIT) ? 1'b0 : (~s_d.dir2[i] & (~s_d.od[i] | ~s_d.lat2[i]));
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.init <= 1'b1;
      s_q.status <= STATUS_RST;
      s_q.ctrl <= CTRL_RST;
      s_q.dir1 <= DIR_RST;
      s_q.dir2 <= DIR_RST;
      s_q.pdn <= PULL_RST;
      s_q.od <= OPENDR_RST;
      s_q.pup <= PULL_RST;
      s_q.wdc <= WD_RST;
      s_q.mask <= MASK_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = s_q.rdata;
  assign reg_rvalid = s_q.rvalid;
  assign prog_addr = pc_val;
  assign port1_out = s_q.p1_out;
  assign port1_oe = s_q.p1_oe;
  assign port2_out = s_q.p2_out;
  assign port2_oe = s_q.p2_oe;
  assign pull_down_ctl = s_q.pdn;
  assign pull_up_ctl = s_q.pup;
  assign wdt_enable = s_q.wdc[WD_EN];
  assign global_int_enable = s_q.ctrl[CT_IEN];
endmodule

// ==== mcuor_regs_bench.sv ====
// Purpose: Self-checking bench of the register bank.
// Assumes: Register bus pulses, read answer one cycle later.
// Notes: Core model drives program counter requests.
module mcuor_regs_bench
  import mcuor_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, reg_rd, reg_wr, reg_ioc_page, reg_rvalid, pc_flush, tcc_pin;
  logic pc_advance, pc_jump, pc_call, pc_ret, alu_flag_we, alu_zero, alu_dc, alu_carry;
  logic sleep_exec, wdt_clear_exec, wdt_timeout, cause_pin_wake, cause_wdt, wdt_osc_tick;
  logic [5:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, port2_in, port2_out, port2_oe, pull_down_ctl, pull_up_ctl;
  logic [9:0] pc_target, prog_addr;
  logic [3:0] port1_in, port1_out, port1_oe;
  logic wdt_enable, global_int_enable, wdt_prescale_tick;
  int n_errors = 0;
  int check_count = 0;

  mcuor_regs u_dut (.clk(clk), .nrst(nrst), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_ioc_page(reg_ioc_page),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .pc_advance(pc_advance), .pc_jump(pc_jump), .pc_call(pc_call), .pc_ret(pc_ret),
    .pc_target(pc_target), .prog_addr(prog_addr), .pc_flush(pc_flush), .alu_flag_we(alu_flag_we),
    .alu_zero(alu_zero), .alu_dc(alu_dc), .alu_carry(alu_carry), .sleep_exec(sleep_exec),
    .wdt_clear_exec(wdt_clear_exec), .wdt_timeout(wdt_timeout), .cause_pin_wake(cause_pin_wake),
    .cause_wdt(cause_wdt), .wdt_osc_tick(wdt_osc_tick), .tcc_pin(tcc_pin), .port1_in(port1_in),
    .port1_out(port1_out), .port1_oe(port1_oe), .port2_in(port2_in), .port2_out(port2_out),
    .port2_oe(port2_oe), .pull_down_ctl(pull_down_ctl), .pull_up_ctl(pull_up_ctl), .wdt_enable(wdt_enable),
    .global_int_enable(global_int_enable), .wdt_prescale_tick(wdt_prescale_tick));
  mcuor_core_model u_core (.clk(clk), .pc_advance(pc_advance), .pc_jump(pc_jump), .pc_call(pc_call),
    .pc_ret(pc_ret), .pc_target(pc_target));

  // Clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Watchdog on a hung run
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    $display("timeout");
    end_sim();
  end
  // ****
  // Helpers
  // ****
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic pg, input logic [5:0] a, input logic [7:0] d);
    reg_ioc_page <= pg;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic pg, input logic [5:0] a, input logic [7:0] exp);
    reg_ioc_page <= pg;
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("rd %0d:%h", pg, a), {8'h01, exp}, {7'h00, reg_rvalid, reg_rdata});
    @(posedge clk);
  endtask
  task automatic pcc(input logic [9:0] exp);
    #1;
    chk("prog_addr", {6'h00, exp}, {6'h00, prog_addr});
  endtask
  task automatic timer_counter(input logic v);
    tcc_pin <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic done(input string name);
    $display("test %s done", name);
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    {nrst, reg_rd, reg_wr, reg_ioc_page, alu_flag_we, alu_zero, alu_dc, alu_carry} = 8'h00;
    {sleep_exec, wdt_clear_exec, wdt_timeout, cause_pin_wake, cause_wdt, wdt_osc_tick} = 6'h00;
    {reg_addr, reg_wdata, port2_in, tcc_pin} = 23'h0;
    port1_in = 4'h5;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    pcc(10'h000);
    chk("pull_down_ctl", 16'h00ff, {8'h00, pull_down_ctl});
    @(posedge clk);
    rd(0, A_STATUS, 8'h18);
    rd(1, A_DIR1, 8'h0f);
    rd(1, A_IMASK, MASK_RST);
    wr(0, 6'h07, 8'h3c);
    rd(0, 6'h07, 8'h00);
    wr(1, 6'h03, 8'h3c);
    rd(1, 6'h03, 8'h00);
    done("reset_map");
    wr(0, A_RAMPTR, 8'hd2);
    rd(0, A_RAMPTR, 8'hd2);
    wr(0, A_INDIRECT, 8'h5a);
    rd(0, 6'h12, 8'h5a);
    wr(0, A_GP_FIRST, 8'h11);
    wr(0, A_GP_LAST, 8'hee);
    wr(0, A_RAMPTR, 8'h2f);
    rd(0, A_INDIRECT, 8'hee);
    rd(0, A_GP_FIRST, 8'h11);
    done("data_space");
    wr(0, A_STATUS, 8'h67);
    rd(0, A_STATUS, 8'h7f);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    rd(0, A_STATUS, 8'h77);
    wdt_timeout <= 1'b1;
    @(posedge clk);
    wdt_timeout <= 1'b0;
    rd(0, A_STATUS, 8'h67);
    wdt_clear_exec <= 1'b1;
    @(posedge clk);
    wdt_clear_exec <= 1'b0;
    rd(0, A_STATUS, 8'h7f);
    {alu_flag_we, alu_zero, alu_dc, alu_carry} <= 4'hd;
    @(posedge clk);
    alu_flag_we <= 1'b0;
    rd(0, A_STATUS, 8'h7d);
    done("status");
    u_core.issue(0, 10'h3f0);
    pcc(10'h3f0);
    u_core.issue(3, 10'h000);
    pcc(10'h3f1);
    u_core.issue(1, 10'h010);
    pcc(10'h010);
    u_core.issue(1, 10'h020);
    u_core.issue(2, 10'h000);
    pcc(10'h011);
    u_core.issue(2, 10'h000);
    pcc(10'h3f2);
    wr(0, A_PC, 8'ha5);
    pcc(10'h0a5);
    @(posedge clk);
    done("program_counter");
    for (int e = 0; e < 2; e++) begin
      wr(1, A_TCTRL, {3'b001, e[0], 4'h8});
      wr(0, A_TIMER, 8'h00);
      timer_counter(1'b1);
      rd(0, A_TIMER, {7'h00, ~e[0]});
      timer_counter(1'b0);
      rd(0, A_TIMER, 8'h01);
    end
    wr(1, A_TCTRL, 8'h20);
    wr(0, A_TIMER, 8'h00);
    timer_counter(1'b1);
    timer_counter(1'b0);
    wr(0, A_TIMER, 8'h00);
    timer_counter(1'b1);
    timer_counter(1'b0);
    rd(0, A_TIMER, 8'h00);
    timer_counter(1'b1);
    rd(0, A_TIMER, 8'h01);
    timer_counter(1'b0);
    wr(1, A_IMASK, 8'h07);
    wr(1, A_TCTRL, 8'h08);
    wr(0, A_TIMER, 8'hf8);
    repeat (20) @(posedge clk);
    wr(1, A_TCTRL, 8'h28);
    rd(0, A_IFLAGS, 8'h01);
    wr(1, A_IMASK, 8'h06);
    rd(0, A_IFLAGS, 8'h00);
    wr(1, A_IMASK, 8'h07);
    wr(0, A_IFLAGS, 8'hfe);
    wr(0, A_IFLAGS, 8'hff);
    rd(0, A_IFLAGS, 8'h00);
    done("timer");
    wr(1, A_WDCTRL, 8'h40);
    port2_in <= 8'h01;
    repeat (3) @(posedge clk);
    rd(0, A_IFLAGS, 8'h02);
    wr(0, A_IFLAGS, 8'h00);
    port2_in <= 8'h00;
    repeat (3) @(posedge clk);
    rd(0, A_IFLAGS, 8'h06);
    rd(0, A_IFLAGS, 8'h06);
    wr(0, A_IFLAGS, 8'h00);
    rd(0, A_IFLAGS, 8'h00);
    done("flags");
    wr(1, A_DIR1, 8'h00);
    wr(0, A_PORT1, 8'hfa);
    rd(0, A_PORT1, 8'h0a);
    chk("port1_out", 16'h000a, {12'h000, port1_out});
    wr(1, A_DIR2, 8'h00);
    wr(0, A_PORT2, 8'hff);
    pcc(10'h0a5);
    chk("port2_out", 16'h00f7, {8'h00, port2_out});
    chk("pins", 16'h7ff8, {port1_oe, pull_up_ctl, wdt_enable, global_int_enable, wdt_prescale_tick});
    done("ports");
    end_sim();
  end
endmodule

// ==== mcuor_regs_monitor.sv ====
// Purpose: Port assertions of the register bank.
// Assumes: One clock domain, reset nrst async low.
// Notes: Bound to every mcuor_regs instance.
module mcuor_regs_monitor
  import mcuor_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_ioc_page,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic pc_jump,
  input wire logic pc_call,
  input wire logic pc_ret,
  input wire logic [PC_W-1:0] pc_target,
  input wire logic [PC_W-1:0] prog_addr,
  input wire logic pc_flush,
  input wire logic [7:0] port2_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mcb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ****
  // Program counter
  // ****
  property p_jump;
    pc_jump && !pc_flush |=> pc_flush && prog_addr == $past(pc_target);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target not loaded");
  property p_call;
    pc_call && !pc_jump && !pc_flush |=> prog_addr == $past(pc_target);
  endproperty
  a_call: assert property (p_call) else $error("call target not loaded");
  property p_ret;
    pc_ret && !pc_jump && !pc_call && !pc_flush |=> pc_flush;
  endproperty
  a_ret: assert property (p_ret) else $error("return not taken");
  property p_pcw;
    reg_wr && !reg_ioc_page && reg_addr == A_PC && !pc_flush && !(pc_jump || pc_call || pc_ret)
      |=> prog_addr == {2'b00, $past(reg_wdata)};
  endproperty
  a_pcw: assert property (p_pcw) else $error("counter write wrong");
  property p_flush;
    pc_flush |=> !pc_flush && $stable(prog_addr);
  endproperty
  a_flush: assert property (p_flush) else $error("extra cycle wrong");
  // ****
  // Register reads and pins
  // ****
  property p_p1hi;
    reg_rd && !reg_ioc_page && reg_addr == A_PORT1 |=> reg_rdata[7:4] == 4'h0;
  endproperty
  a_p1hi: assert property (p_p1hi) else $error("port upper bits set");
  property p_ifl;
    reg_rd && !reg_ioc_page && reg_addr == A_IFLAGS |=> reg_rvalid && (reg_rdata & ~IF_MASK) == 8'h00;
  endproperty
  a_ifl: assert property (p_ifl) else $error("flag read bits wrong");
  property p_rsv;
    reg_rd && !reg_ioc_page && reg_addr inside {[6'h07:6'h0e]} |=> reg_rdata == 8'h00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved read not zero");
  property p_inonly;
    port2_oe[3] == 1'b0;
  endproperty
  a_inonly: assert property (p_inonly) else $error("input pin driven");
endmodule

bind mcuor_regs mcuor_regs_monitor u_mon (.clk(clk), .nrst(nrst), .reg_rd(reg_rd), .reg_wr(reg_wr),
  .reg_ioc_page(reg_ioc_page), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .pc_jump(pc_jump), .pc_call(pc_call), .pc_ret(pc_ret),
  .pc_target(pc_target), .prog_addr(prog_addr), .pc_flush(pc_flush), .port2_oe(port2_oe));

// ==== mcuor_timer.sv ====
// Purpose: Timer/counter with the shared prescaler.
// Assumes: Count pin is synchronous to clk.
// Notes: Prescaler serves either the counter or the watchdog.
module mcuor_timer
  import mcuor_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ext_pin,
  input wire logic src_ext,
  input wire logic edge_fall,
  input wire logic pre_to_wdt,
  input wire logic [2:0] rate,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic wdt_osc_tick,
  input wire logic wdt_clear,
  output logic [7:0] count,
  output logic ovf,
  output logic wdt_tick
);
  typedef struct packed {
    logic pin;
    logic [7:0] pre;
    logic [7:0] cnt;
    logic ovf;
    logic wtick;
  } mcuor_tmr_s;

  mcuor_tmr_s s_q, s_d;
  logic src_evt, pre_evt, pre_done, inc;
  logic [7:0] pmask;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.pin = ext_pin;
    // Count source: pin edge or every instruction cycle
    if (src_ext) begin
      src_evt = edge_fall ? (s_q.pin & ~ext_pin) : (~s_q.pin & ext_pin);
    end else begin
      src_evt = 1'b1;
    end
    pre_evt = pre_to_wdt ? wdt_osc_tick : src_evt;
    // Ratio 1:2^(rate+1) for counter, 1:2^rate for watchdog
    if (pre_to_wdt) begin
      pmask = 8'((9'h001 << rate) - 9'h001);
    end else begin
      pmask = 8'((9'h002 << rate) - 9'h001);
    end
    pre_done = pre_evt & (&(s_q.pre | ~pmask));
    inc = pre_to_wdt ? src_evt : pre_done;
    s_d.ovf = 1'b0;
    s_d.wtick = pre_to_wdt & pre_done;
    if (pre_evt) begin
      s_d.pre = pre_done ? 8'h00 : s_q.pre + 8'h01;
    end
    if (pre_to_wdt && wdt_clear) begin
      s_d.pre = 8'h00;
    end
    if (wr) begin
      s_d.cnt = wdata;
      s_d.pre = 8'h00;
    end else if (inc) begin
      s_d.cnt = s_q.cnt + 8'h01;
      s_d.ovf = (s_q.cnt == 8'hff);
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count = s_q.cnt;
  assign ovf = s_q.ovf;
  assign wdt_tick = s_q.wtick;
endmodule
